// *** core/phr_pkg.sv ***
// Constants, state type and mixing functions for the health-gated RNG
// Operation
// - Check the entropy source for total failure from start; on failure output nothing
// - Never release a word built from raw bits sampled after a total failure
// - Statistically test the raw bit stream at startup and during operation
// - Physical mode: no output before the startup test passes or after defects
// - Hybrid mode: no output before startup test and seeding finish, or after defects
// - Online test scans every raw bit continuously and detects within bounded time
// - Random words reach the consumer as 8-bit or 16-bit words
// - Physical mode bits are conditioned to near-full entropy per bit
// - Hybrid post-processor emits at most one bit per conditioned input bit
// - Quality class, physical or hybrid, follows the user configuration
// - Hybrid post-processor is fed by the tested physical generator bits
package phr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Longest wait for a raw bit before the source counts as dead
  localparam int unsigned SRC_TIMEOUT_NS = 10000;
  localparam int unsigned SRC_TIMEOUT_CYC = SRC_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned TF_RUN_BITS = 32;
  localparam int unsigned WIN_BITS = 256;
  localparam int unsigned WIN_ONES_LO = 96;
  localparam int unsigned WIN_ONES_HI = 160;
  localparam int unsigned SEED_BITS = 256;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PP_W = 64;
  // Arbitrary neutral values
  localparam logic [63:0] PP_INIT = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] PP_KEY = 64'h5a5a_3c3c_0f0f_9696;
  localparam logic [63:0] PP_OUT_MASK = 64'hf0e1_d2c3_b4a5_9687;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'h0,
    ST_SEED = 2'h1,
    ST_RUN = 2'h3,
    ST_FAIL = 2'h2
  } phr_state_t;

  // State transition of the post-processor, one absorbed bit per call
  function automatic logic [63:0] pp_mix(input logic [63:0] s,
                                         input logic b);
    logic [63:0] t;
    t = s ^ {63'h0, b};
    t = t + {t[50:0], t[63:51]};
    t = t ^ {t[56:0], t[63:57]} ^ PP_KEY;
    return t;
  endfunction : pp_mix

  // Output function of the post-processor
  function automatic logic pp_out(input logic [63:0] s);
    return ^(s & PP_OUT_MASK);
  endfunction : pp_out

  // Ones count of a window lies inside the accepted band
  function automatic logic ones_ok(input int unsigned n);
    return (n >= WIN_ONES_LO) && (n <= WIN_ONES_HI);
  endfunction : ones_ok
endpackage : phr_pkg

// *** core/phr_fifo_if.sv ***
// Carrier between the generator core and its word FIFO
`timescale 1ns/1ns
interface phr_fifo_if #(
  parameter int unsigned W = 17
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic flush;
  modport writer (
    output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data
  );
  modport store (
    input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data
  );
endinterface : phr_fifo_if

// *** core/phr_fifo.sv ***
// Word FIFO with flush, valid and ready on both sides
`timescale 1ns/1ns
module phr_fifo #(
  parameter int unsigned W = 17,
  parameter int unsigned D = 16
)(
  input wire logic clk_i,
  input wire logic reset_n_i,
  phr_fifo_if.store f
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // Honest full and empty from the fill count
  assign f.push_ready = (cnt_q != CW'(D)) && !f.flush;
  assign f.pop_valid = (cnt_q != '0) && !f.flush;
  assign f.pop_data = mem[rd_q];
  assign do_push = f.push_valid && f.push_ready;
  assign do_pop = f.pop_valid && f.pop_ready;

  // Pointer and count update; flush drops everything at once
  always_comb
  begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (do_push)
      wr_d = (wr_q == AW'(D - 1)) ? '0 : wr_q + AW'(1);
    if (do_pop)
      rd_d = (rd_q == AW'(D - 1)) ? '0 : rd_q + AW'(1);
    if (do_push && !do_pop)
      cnt_d = cnt_q + CW'(1);
    else if (do_pop && !do_push)
      cnt_d = cnt_q - CW'(1);
    if (f.flush)
    begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem[wr_q] <= f.push_data;
  end
endmodule : phr_fifo

// *** core/phr_rng.sv ***
// Health-gated physical and hybrid random word generator
`timescale 1ns/1ns
module phr_rng #(
  parameter int unsigned TF_RUN = phr_pkg::TF_RUN_BITS,
  parameter int unsigned TIMEOUT = phr_pkg::SRC_TIMEOUT_CYC,
  parameter int unsigned WIN = phr_pkg::WIN_BITS,
  parameter int unsigned SEED = phr_pkg::SEED_BITS,
  parameter int unsigned DEPTH = phr_pkg::FIFO_DEPTH
)(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic raw_bit_i,
  input wire logic raw_toggle_i,
  input wire logic mode_hybrid_i,
  input wire logic word16_i,
  input wire logic rd_ready_i,
  output logic [15:0] rd_data_o,
  output logic rd_wide_o,
  output logic rd_valid_o,
  output logic ready_o,
  output logic fail_o
);
  localparam int RW = $clog2(TF_RUN + 1);
  localparam int IW = $clog2(TIMEOUT + 1);
  localparam int WW = $clog2(WIN);
  localparam int OW = $clog2(WIN + 1);
  localparam int SW = $clog2(SEED + 1);
  localparam int FW = phr_pkg::WORD_W + 1;

  phr_fifo_if #(.W(FW)) fq ();

  logic bit_s1_q, bit_s2_q, tog_s1_q, tog_s2_q, tog_s3_q;
  logic raw_stb, raw_bit;
  logic [2:0] prime_q;
  logic last_bit_q, last_bit_d;
  logic [RW-1:0] run_q, run_d;
  logic [IW-1:0] idle_q, idle_d;
  logic [WW-1:0] win_q, win_d;
  logic [OW-1:0] ones_q, ones_d;
  logic win_ok_q, win_ok_d;
  logic tf_fail_q, tf_fail_d, ol_fail_q, ol_fail_d;
  logic failing;
  logic vn_have_q, vn_have_d, vn_first_q, vn_first_d;
  logic cond_stb, cond_bit;
  phr_pkg::phr_state_t state_q, state_d;
  logic mode_q, mode_d;
  logic [SW-1:0] seed_q, seed_d;
  logic [63:0] pp_q, pp_d;
  logic out_bit, bit_stb, wide_now;
  logic [15:0] asm_q, asm_d;
  logic [4:0] acnt_q, acnt_d;
  logic aw16_q, aw16_d;
  logic [FW-1:0] hold_q, hold_d;
  logic hold_vld_q, hold_vld_d;
  logic [RW-1:0] age_q, age_d;
  logic [15:0] data_d;
  logic wide_d, valid_d, ready_d, fail_d;

  // Source pins pass two flops; third stage only forms the toggle edge
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      bit_s1_q <= 1'b0;
      bit_s2_q <= 1'b0;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      prime_q <= 3'h0;
    end
    else
    begin
      prime_q <= {prime_q[1:0], 1'b1};
      bit_s1_q <= raw_bit_i;
      bit_s2_q <= bit_s1_q;
      tog_s1_q <= raw_toggle_i;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end
  // Edge stage is blind until it holds a real pin level; a toggle pin
  // resting high at reset would otherwise look like a fresh raw bit
  assign raw_stb = (tog_s2_q ^ tog_s3_q) && prime_q[2];
  assign raw_bit = bit_s2_q;
  assign failing = tf_fail_q | ol_fail_q | fail_o;

  // Health tests on every raw bit: stuck run, silence, window ones count
  always_comb
  begin
    last_bit_d = last_bit_q;
    run_d = run_q;
    idle_d = idle_q;
    win_d = win_q;
    ones_d = ones_q;
    win_ok_d = win_ok_q;
    tf_fail_d = tf_fail_q;
    ol_fail_d = ol_fail_q;
    if (raw_stb)
    begin
      last_bit_d = raw_bit;
      idle_d = '0;
      run_d = (raw_bit == last_bit_q) ? run_q + RW'(1) : RW'(1);
      if (run_d >= RW'(TF_RUN))
        tf_fail_d = 1'b1;
      ones_d = ones_q + OW'(raw_bit);
      win_d = win_q + WW'(1);
      if (win_q == WW'(WIN - 1))
      begin
        // Window closes; first pass is the startup test
        if (!phr_pkg::ones_ok(int'(ones_d)))
          ol_fail_d = 1'b1;
        else
          win_ok_d = 1'b1;
        ones_d = '0;
        win_d = '0;
      end
    end
    else if (idle_q != IW'(TIMEOUT))
      idle_d = idle_q + IW'(1);
    else
      tf_fail_d = 1'b1;
  end

  // Von Neumann pairing removes bias before any use
  always_comb
  begin
    vn_have_d = vn_have_q;
    vn_first_d = vn_first_q;
    cond_stb = 1'b0;
    cond_bit = vn_first_q;
    if (raw_stb)
    begin
      vn_have_d = !vn_have_q;
      vn_first_d = vn_have_q ? vn_first_q : raw_bit;
      cond_stb = vn_have_q && (vn_first_q != raw_bit);
    end
  end

  // Mode latch, seeding and post-processor state
  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    seed_d = seed_q;
    pp_d = pp_q;
    case (state_q)
      phr_pkg::ST_STARTUP:
      begin
        mode_d = mode_hybrid_i;
        if (win_ok_q)
          state_d = mode_hybrid_i ? phr_pkg::ST_SEED : phr_pkg::ST_RUN;
      end
      phr_pkg::ST_SEED:
      begin
        if (cond_stb)
          seed_d = seed_q + SW'(1);
        if (seed_q == SW'(SEED))
          state_d = phr_pkg::ST_RUN;
      end
      phr_pkg::ST_RUN: state_d = phr_pkg::ST_RUN;
      phr_pkg::ST_FAIL: state_d = phr_pkg::ST_FAIL;
      default: state_d = phr_pkg::ST_FAIL;
    endcase
    // Only conditioned physical bits, one per step, feed the state
    if (mode_q && cond_stb && state_q != phr_pkg::ST_STARTUP)
      pp_d = phr_pkg::pp_mix(pp_q, cond_bit);
    if (failing)
      state_d = phr_pkg::ST_FAIL;
  end
  assign out_bit = mode_q ? phr_pkg::pp_out(pp_d) : cond_bit;
  assign bit_stb = cond_stb && (state_q == phr_pkg::ST_RUN) &&
                   !hold_vld_q && !failing;
  assign wide_now = (acnt_q == 5'h0) ? word16_i : aw16_q;

  // Word assembly and hold stage; a word waits TF_RUN raw bits so that
  // a stuck source starting inside it is caught before release
  always_comb
  begin
    asm_d = asm_q;
    acnt_d = acnt_q;
    aw16_d = wide_now;
    hold_d = hold_q;
    hold_vld_d = hold_vld_q;
    age_d = age_q;
    if (hold_vld_q && raw_stb && age_q != RW'(TF_RUN))
      age_d = age_q + RW'(1);
    if (fq.push_valid && fq.push_ready)
      hold_vld_d = 1'b0;
    if (bit_stb)
    begin
      asm_d = {asm_q[14:0], out_bit};
      acnt_d = acnt_q + 5'h1;
      if (acnt_d == (wide_now ? 5'h10 : 5'h08))
      begin
        hold_d = {wide_now, asm_d};
        hold_vld_d = 1'b1;
        age_d = '0;
        asm_d = '0;
        acnt_d = '0;
      end
    end
    if (failing)
    begin
      hold_vld_d = 1'b0;
      acnt_d = '0;
      asm_d = '0;
    end
  end
  assign fq.push_valid = hold_vld_q && (age_q == RW'(TF_RUN)) && !failing;
  assign fq.push_data = hold_q;
  assign fq.flush = failing;
  assign fq.pop_ready = (!rd_valid_o || rd_ready_i) && !failing;

  // Consumer output stage and status flags
  always_comb
  begin
    data_d = rd_data_o;
    wide_d = rd_wide_o;
    valid_d = rd_valid_o && !rd_ready_i;
    if (fq.pop_valid && fq.pop_ready)
    begin
      data_d = fq.pop_data[15:0];
      wide_d = fq.pop_data[16];
      valid_d = 1'b1;
    end
    if (failing)
    begin
      valid_d = 1'b0;
      data_d = '0;
    end
    ready_d = (state_q == phr_pkg::ST_RUN) && !failing;
    fail_d = fail_o | tf_fail_q | ol_fail_q;
  end

  phr_fifo #(.W(FW), .D(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .f(fq.store)
  );

  // All state registers past the source synchronizer
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      last_bit_q <= 1'b0;
      run_q <= '0;
      idle_q <= '0;
      win_q <= '0;
      ones_q <= '0;
      win_ok_q <= 1'b0;
      tf_fail_q <= 1'b0;
      ol_fail_q <= 1'b0;
      vn_have_q <= 1'b0;
      vn_first_q <= 1'b0;
      state_q <= phr_pkg::ST_STARTUP;
      mode_q <= 1'b0;
      seed_q <= '0;
      pp_q <= phr_pkg::PP_INIT;
      asm_q <= '0;
      acnt_q <= '0;
      aw16_q <= 1'b0;
      hold_q <= '0;
      hold_vld_q <= 1'b0;
      age_q <= '0;
      rd_data_o <= '0;
      rd_wide_o <= 1'b0;
      rd_valid_o <= 1'b0;
      ready_o <= 1'b0;
      fail_o <= 1'b0;
    end
    else
    begin
      last_bit_q <= last_bit_d;
      run_q <= run_d;
      idle_q <= idle_d;
      win_q <= win_d;
      ones_q <= ones_d;
      win_ok_q <= win_ok_d;
      tf_fail_q <= tf_fail_d;
      ol_fail_q <= ol_fail_d;
      vn_have_q <= vn_have_d;
      vn_first_q <= vn_first_d;
      state_q <= state_d;
      mode_q <= mode_d;
      seed_q <= seed_d;
      pp_q <= pp_d;
      asm_q <= asm_d;
      acnt_q <= acnt_d;
      aw16_q <= aw16_d;
      hold_q <= hold_d;
      hold_vld_q <= hold_vld_d;
      age_q <= age_d;
      rd_data_o <= data_d;
      rd_wide_o <= wide_d;
      rd_valid_o <= valid_d;
      ready_o <= ready_d;
      fail_o <= fail_d;
    end
  end

  property p_tf_block;
    @(posedge clk_i) disable iff (!reset_n_i)
    tf_fail_q |=> !rd_valid_o [*4];
  endproperty
  a_tf_block: assert property (p_tf_block)
    else $error("output valid after total failure");

  property p_stuck_run;
    @(posedge clk_i) disable iff (!reset_n_i)
    raw_stb && raw_bit == last_bit_q && run_q == RW'(TF_RUN - 1)
      |=> tf_fail_q ##1 fail_o;
  endproperty
  a_stuck_run: assert property (p_stuck_run)
    else $error("stuck source not flagged");

  property p_push_aged;
    @(posedge clk_i) disable iff (!reset_n_i)
    fq.push_valid |-> age_q == RW'(TF_RUN) && !tf_fail_q;
  endproperty
  a_push_aged: assert property (p_push_aged)
    else $error("word released before aging");

  property p_window_fail;
    @(posedge clk_i) disable iff (!reset_n_i)
    raw_stb && win_q == WW'(WIN - 1) &&
      !phr_pkg::ones_ok(int'(ones_q) + int'(raw_bit)) |=> ol_fail_q;
  endproperty
  a_window_fail: assert property (p_window_fail)
    else $error("window defect not flagged");

  property p_startup_block;
    @(posedge clk_i) disable iff (!reset_n_i)
    !win_ok_q |-> !rd_valid_o && !fq.push_valid;
  endproperty
  a_startup_block: assert property (p_startup_block)
    else $error("output before startup test");

  property p_seeded;
    @(posedge clk_i) disable iff (!reset_n_i)
    mode_q && $rose(state_q == phr_pkg::ST_RUN) |-> seed_q == SW'(SEED);
  endproperty
  a_seeded: assert property (p_seeded)
    else $error("hybrid run before seeding");

  property p_scan_all;
    @(posedge clk_i) disable iff (!reset_n_i)
    raw_stb |=> win_q != $past(win_q) && idle_q == '0;
  endproperty
  a_scan_all: assert property (p_scan_all)
    else $error("raw bit not scanned");

  property p_narrow;
    @(posedge clk_i) disable iff (!reset_n_i)
    rd_valid_o && !rd_wide_o |-> rd_data_o[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("byte word has upper bits set");

  property p_unbiased;
    @(posedge clk_i) disable iff (!reset_n_i)
    cond_stb |-> vn_have_q && raw_bit != vn_first_q;
  endproperty
  a_unbiased: assert property (p_unbiased)
    else $error("conditioned bit from equal pair");

  property p_pp_feed;
    @(posedge clk_i) disable iff (!reset_n_i)
    !cond_stb |=> $stable(pp_q);
  endproperty
  a_pp_feed: assert property (p_pp_feed)
    else $error("post-processor moved without input");

  property p_mode_cfg;
    @(posedge clk_i) disable iff (!reset_n_i)
    state_q == phr_pkg::ST_STARTUP |=> mode_q == $past(mode_hybrid_i);
  endproperty
  a_mode_cfg: assert property (p_mode_cfg)
    else $error("mode not taken from configuration");

  property p_sticky;
    @(posedge clk_i) disable iff (!reset_n_i)
    (tf_fail_q || ol_fail_q) |=> fail_o [*8];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("failure flag not sticky");
endmodule : phr_rng

// *** test/phr_consumer.sv ***
// Consumer model that takes random words from the generator
`timescale 1ns/1ns
module phr_consumer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic stall_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_wide_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  output logic take_o,
  output logic [16:0] take_word_o,
  output logic hold_bad_o
);
  logic rdy_q = 1'b0;
  logic wait_q = 1'b0;
  logic [16:0] last_q = 17'h0;
  logic bad_q = 1'b0;
  // Ready moves off the sampling edge only, like a real core
  always @(negedge clk_i)
  begin
    rdy_q <= !stall_i;
  end
  assign rd_ready_o = rdy_q;
  assign take_o = rd_valid_i && rdy_q;
  assign take_word_o = {rd_wide_i, rd_data_i};
  assign hold_bad_o = bad_q;
  // An offered word that is not taken must stand unchanged
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      wait_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else
    begin
      if (wait_q && rd_valid_i && take_word_o !== last_q)
        bad_q <= 1'b1;
      wait_q <= rd_valid_i && !rdy_q;
      last_q <= take_word_o;
    end
  end
endmodule : phr_consumer

// *** test/testbench.sv ***
// Self-checking bench for the health-gated random word generator
`timescale 1ns/1ns
module testbench;
  localparam int unsigned TFR = 8;
  localparam int unsigned TMO = 50;
  localparam int unsigned SDN = 16;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic raw_bit_i = 1'b0;
  logic raw_toggle_i = 1'b0;
  logic mode_hybrid_i = 1'b0;
  logic word16_i = 1'b1;
  logic stall = 1'b0;
  logic rd_ready_i, rd_wide_o, rd_valid_o, ready_o, fail_o, take, hold_bad;
  logic [15:0] rd_data_o;
  logic [16:0] take_word;
  logic [31:0] lfsr_q = 32'h28e7;
  logic seen_ready = 1'b0;
  logic [1:0] fail_d = 2'h0;
  logic [16:0] words[$];
  int error_cnt = 0;
  int tests_run = 0;
  int src_mode = 0;
  int rand_stall = 0;
  int k = 0;
  int t0, t_phys, n0, nc;

  phr_rng #(
    .TF_RUN(TFR), .TIMEOUT(TMO), .WIN(256), .SEED(SDN), .DEPTH(16)
  ) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .raw_bit_i(raw_bit_i),
    .raw_toggle_i(raw_toggle_i), .mode_hybrid_i(mode_hybrid_i),
    .word16_i(word16_i), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o),
    .rd_wide_o(rd_wide_o), .rd_valid_o(rd_valid_o), .ready_o(ready_o),
    .fail_o(fail_o)
  );
  phr_consumer u_cons (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .stall_i(stall),
    .rd_data_i(rd_data_o), .rd_wide_i(rd_wide_o), .rd_valid_i(rd_valid_o),
    .rd_ready_o(rd_ready_i), .take_o(take), .take_word_o(take_word),
    .hold_bad_o(hold_bad)
  );

  // Free-running 100 MHz clock
  initial
  begin
    forever
    begin
      #5 clk_i = !clk_i;
    end
  end

  // Fibonacci step, taps 32 22 2 1
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Alternating raw bits condition to one constant bit per pair alignment
  function automatic logic [16:0] fill_word(input logic wide, input logic b);
    return wide ? {1'b1, {16{b}}} : {1'b0, 8'h00, {8{b}}};
  endfunction : fill_word

  task automatic chk_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t word %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Bounded wait: 0 ready, 1 failure, 2 at least n words taken
  task automatic wait_for(input int what, input int n, input int bound);
    int c;
    c = 0;
    while (!((what == 0 && ready_o === 1'b1) ||
             (what == 1 && fail_o === 1'b1) || (what == 2 && words.size() >= n)))
    begin
      @(negedge clk_i);
      c++;
      if (c > bound)
      begin
        error_cnt++;
        $display("BAD t=%0t wait %0d ran out", $time, what);
        finish_test();
      end
    end
  endtask : wait_for

  task automatic do_reset(input logic hyb);
    reset_n_i = 1'b0;
    src_mode = 0;
    rand_stall = 0;
    mode_hybrid_i = hyb;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    words.delete();
    @(negedge clk_i);
    chk_bit(ready_o | fail_o | rd_valid_o, 1'b0, "reset outputs");
    t0 = int'($time / 10);
  endtask : do_reset

  task automatic end_test(input string name);
    chk_bit(hold_bad, 1'b0, "word changed while offered");
    $display("test %s done: checks %0d bad %0d", name, tests_run, error_cnt);
  endtask : end_test

  // Random stalls and word width, launched off the falling edge
  always @(negedge clk_i)
  begin
    lfsr_q <= lfsr_next(lfsr_q);
    stall <= (rand_stall == 2) || (rand_stall == 1 && lfsr_q[3]);
    word16_i <= lfsr_q[7];
  end

  // Raw source, one toggle per five cycles so the sync never merges them
  initial
  begin
    forever
    begin
      @(negedge clk_i);
      k = k + 1;
      if (src_mode != 0)
      begin
        case (src_mode)
          1: raw_bit_i <= k[0];
          2: raw_bit_i <= k[0] ? !raw_bit_i : lfsr_q[0];
          3: raw_bit_i <= 1'b1;
          default: raw_bit_i <= (k % 7) != 0;
        endcase
        raw_toggle_i <= !raw_toggle_i;
      end
      repeat (4) @(negedge clk_i);
    end
  end

  // Gate watch: no word before the health pass or after a failure
  always @(posedge clk_i)
  begin
    fail_d <= {fail_d[0], fail_o};
    if (!reset_n_i)
      seen_ready <= 1'b0;
    else if (ready_o)
      seen_ready <= 1'b1;
    if (reset_n_i && rd_valid_o && ((!seen_ready && !ready_o) || fail_d[1]))
      chk_bit(1'b1, 1'b0, "word while blocked");
    if (take)
      words.push_back(take_word);
  end

  initial
  begin
    do_reset(1'b0);
    src_mode = 1;
    wait_for(0, 0, 4000);
    t_phys = int'($time / 10) - t0;
    rand_stall = 1;
    wait_for(2, 6, 6000);
    // Hold the consumer off until the FIFO refuses, then drain back to back
    rand_stall = 2;
    repeat (3500) @(negedge clk_i);
    n0 = words.size();
    rand_stall = 0;
    repeat (40) @(negedge clk_i);
    chk_bit(words.size() >= n0 + 16, 1'b1, "fifo drain");
    foreach (words[j])
      chk_word(words[j], fill_word(words[j][16], words[0][0]));
    // Source falls silent in mid-run
    src_mode = 0;
    repeat (TMO - 10) @(negedge clk_i);
    chk_bit(fail_o, 1'b0, "early timeout");
    wait_for(1, 0, 40);
    n0 = words.size();
    src_mode = 1;
    repeat (600) @(negedge clk_i);
    chk_bit(fail_o, 1'b1, "sticky fail");
    chk_bit(ready_o | rd_valid_o | (|rd_data_o), 1'b0, "not blocked");
    chk_bit(words.size() == n0, 1'b1, "word after fail");
    end_test("physical");
    // Hybrid start; later mode change and alternating raw must not leak through
    do_reset(1'b1);
    src_mode = 2;
    wait_for(0, 0, 4000);
    chk_bit(int'($time / 10) - t0 >= t_phys + SDN * 10 - 20, 1'b1,
            "seed gap");
    mode_hybrid_i = 1'b0;
    src_mode = 1;
    words.delete();
    wait_for(2, 8, 4000);
    nc = 0;
    foreach (words[j])
      if (words[j] !== fill_word(words[j][16], 1'b0) &&
          words[j] !== fill_word(words[j][16], 1'b1))
        nc++;
    chk_bit(nc >= 4, 1'b1, "hybrid not mixed");
    src_mode = 4;
    wait_for(1, 0, 2 * 256 * 5 + 200);
    chk_bit(ready_o, 1'b0, "ready after defect");
    end_test("hybrid");
    // Stuck source right from start
    do_reset(1'b0);
    src_mode = 3;
    wait_for(1, 0, (TFR + 4) * 5 + 20);
    chk_bit(seen_ready, 1'b0, "ready on dead source");
    end_test("stuck");
    // Biased source fails the power-up window
    do_reset(1'b0);
    src_mode = 4;
    wait_for(1, 0, 2 * 256 * 5 + 200);
    chk_bit(seen_ready, 1'b0, "ready on biased source");
    end_test("biased");
    finish_test();
  end
endmodule : testbench
